// *** logic/adc_sync_clock_qec_control_regs.sv ***
// Control register bank: sync gating, backup oscillator, pin controls, I/Q correction settings.
// Assumes the serial port decoder runs on clk_sys; sync, encode and output-enable pins are asynchronous.
// What this block does
// - No sync function acts unless the master sync enable bit is high.
// - Sync pulses reach the divider only while divider and master sync enables are high.
// - With next-sync-only low, the divider resyncs on every passed pulse.
// - With next-sync-only high, only the first pulse passes; later pulses are ignored.
// - In one-shot mode hardware clears the divider sync enable after syncing.
// - User bit 7 high lets the output-enable pin steer outputs; low ignores it.
// - Detect bit high turns on backup oscillator when encode rate drops below 5 MSPS.
// - Run-oscillator bit forces the backup oscillator on regardless of the detector.
// - User bit 0 high disconnects the serial data pin pull-down.
// - Each freeze bit holds its correction value and halts that error's estimation.
// - Separate enables switch dc, phase and gain corrections independently.
// - Force-dc selects the static in-phase and quadrature dc values.
// - Force-phase selects the static initial phase value.
// - Force-gain selects the static initial gain value.
// - Five-bit exponent sets the gain loop time constant.
// - Five-bit exponent sets the phase loop time constant.
// - Five-bit exponent sets the dc loop time constant.
// - Phase value is 13 bits: low byte, then bits 12 to 8.
// - Gain value is 15 bits, used while force-gain is set.
// - Dc values are 14 bits each, used while force-dc is set.
`timescale 1ns/100ps
`default_nettype none
module adc_sync_clock_qec_control_regs (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [12:0] regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData,
  output logic             regRdValid,
  input  wire logic        syncPin,
  input  wire logic        encodeClkPin,
  input  wire logic        outputEnablePin_b,
  output logic             dividerSyncPulse,
  output logic             dataOutputEnable,
  output logic             backupLowRateOscillator,
  output logic             sdioPullDownEnable,
  output logic             overflowPinEnable,
  output logic             outputChannelSelect,
  output logic             gainCorrEnable,
  output logic             phaseCorrEnable,
  output logic             dcCorrEnable,
  output logic             gainFreeze,
  output logic             phaseFreeze,
  output logic             dcFreeze,
  output logic             gainForceStatic,
  output logic             phaseForceStatic,
  output logic             dcForceStatic,
  output logic      [4:0]  gainLoopExponent,
  output logic      [4:0]  phaseLoopExponent,
  output logic      [4:0]  dcLoopExponent,
  output logic      [14:0] initialGain,
  output logic      [12:0] initialPhase,
  output logic      [13:0] initialDcInphase,
  output logic      [13:0] initialDcQuadrature
);

  logic [7:0] regFile_reg [adc_ctrl_pkg::NUM_REGS];
  logic [4:0] accessIdx;
  logic       syncMeta_reg;
  logic       syncSafe_reg;
  logic       syncLast_reg;
  logic       encMeta_reg;
  logic       encSafe_reg;
  logic       encLast_reg;
  logic       oePinMeta_reg;
  logic       oePinSafe_reg;
  logic [5:0] periodCnt_reg;
  logic       lowRate_reg;
  logic       dividerSync_reg;
  logic       dataOe_reg;
  logic       backupOsc_reg;
  logic [7:0] rdData_reg;
  logic       rdValid_reg;
  logic       syncEdge;
  logic       syncGate;
  logic       passPulse;
  logic       oneShotClear;
  logic       wrSync;
  logic       encEdge;
  logic       masterEn;
  logic       divEn;
  logic       nextOnly;
  logic       oePinEn;
  logic       detectEn;
  logic       runOsc;

  function automatic logic [4:0] lookupIdx(input logic [12:0] a);
    lookupIdx = 5'(adc_ctrl_pkg::NUM_REGS);
    for (int i = 0; i < adc_ctrl_pkg::NUM_REGS; i++) begin
      if (a == adc_ctrl_pkg::REG_OFS[i]) begin
        lookupIdx = 5'(i);
      end
    end
  endfunction

  assign accessIdx = lookupIdx(regAddr);
  assign wrSync    = regWrEn && (accessIdx == 5'(adc_ctrl_pkg::IDX_SYNC));
  assign masterEn  = regFile_reg[adc_ctrl_pkg::IDX_SYNC][adc_ctrl_pkg::SYNC_MASTER_BIT];
  assign divEn     = regFile_reg[adc_ctrl_pkg::IDX_SYNC][adc_ctrl_pkg::SYNC_DIV_EN_BIT];
  assign nextOnly  = regFile_reg[adc_ctrl_pkg::IDX_SYNC][adc_ctrl_pkg::SYNC_NEXT_ONLY_BIT];
  assign oePinEn   = regFile_reg[adc_ctrl_pkg::IDX_USER_PIN][adc_ctrl_pkg::USR_OE_PIN_EN_BIT];
  assign detectEn  = regFile_reg[adc_ctrl_pkg::IDX_USER_PIN][adc_ctrl_pkg::USR_DETECT_BIT];
  assign runOsc    = regFile_reg[adc_ctrl_pkg::IDX_USER_PIN][adc_ctrl_pkg::USR_RUN_OSC_BIT];

  // Register storage; a software write to the sync register outranks the one-shot clear
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < adc_ctrl_pkg::NUM_REGS; i++) begin
      if (!rst_b) begin
        regFile_reg[i] <= adc_ctrl_pkg::REG_RST[i];
      end else if (regWrEn && accessIdx == 5'(i)) begin
        regFile_reg[i] <= regWrData & adc_ctrl_pkg::REG_MASK[i];
      end else if (i == adc_ctrl_pkg::IDX_SYNC && oneShotClear) begin
        regFile_reg[i][adc_ctrl_pkg::SYNC_DIV_EN_BIT] <= 1'b0;
      end
    end
  end

  // Read port, one cycle latency; unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdData_reg  <= 8'h00;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= regRdEn;
      if (regRdEn) begin
        rdData_reg <= (accessIdx < 5'(adc_ctrl_pkg::NUM_REGS)) ? regFile_reg[accessIdx] : 8'h00;
      end
    end
  end

  // Pin synchronisers; logic uses the second stage, plus a third stage for the sync and encode edge detects
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      syncMeta_reg <= 1'b0;
      syncSafe_reg <= 1'b0;
      syncLast_reg <= 1'b0;
      encMeta_reg  <= 1'b0;
      encSafe_reg  <= 1'b0;
      encLast_reg  <= 1'b0;
      oePinMeta_reg <= 1'b1;
      oePinSafe_reg <= 1'b1;
    end else begin
      syncMeta_reg <= syncPin;
      syncSafe_reg <= syncMeta_reg;
      syncLast_reg <= syncSafe_reg;
      encMeta_reg  <= encodeClkPin;
      encSafe_reg  <= encMeta_reg;
      encLast_reg  <= encSafe_reg;
      oePinMeta_reg <= outputEnablePin_b;
      oePinSafe_reg <= oePinMeta_reg;
    end
  end

  assign syncEdge     = syncSafe_reg && !syncLast_reg;
  assign syncGate     = masterEn && divEn;
  assign passPulse    = syncEdge && syncGate;
  assign oneShotClear = passPulse && nextOnly;
  assign encEdge      = encSafe_reg && !encLast_reg;

  // Continuous mode leaves the enable set, so every gated edge resyncs the divider
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dividerSync_reg <= 1'b0;
    end else begin
      dividerSync_reg <= passPulse;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dataOe_reg <= 1'b1;
    end else begin
      dataOe_reg <= oePinEn ? !oePinSafe_reg : 1'b1;
    end
  end

  // Encode period measured in system cycles; a stopped encode clock saturates and reads as slow.
  // Resolution is one system cycle, so the threshold is only approximate near 5 MSPS.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      periodCnt_reg <= 6'h00;
    end else if (encEdge) begin
      periodCnt_reg <= 6'h00;
    end else if (periodCnt_reg != adc_ctrl_pkg::LOW_RATE_CYCLES) begin
      periodCnt_reg <= periodCnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lowRate_reg <= 1'b0;
    end else if (!detectEn) begin
      lowRate_reg <= 1'b0;
    end else if (encEdge || periodCnt_reg == adc_ctrl_pkg::LOW_RATE_CYCLES) begin
      lowRate_reg <= (periodCnt_reg == adc_ctrl_pkg::LOW_RATE_CYCLES);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      backupOsc_reg <= 1'b0;
    end else begin
      backupOsc_reg <= runOsc || (detectEn && lowRate_reg);
    end
  end

  assign regRdData               = rdData_reg;
  assign regRdValid              = rdValid_reg;
  assign dividerSyncPulse        = dividerSync_reg;
  assign dataOutputEnable        = dataOe_reg;
  assign backupLowRateOscillator = backupOsc_reg;
  assign sdioPullDownEnable      =
    !regFile_reg[adc_ctrl_pkg::IDX_USER_PIN][adc_ctrl_pkg::USR_SDIO_PD_DIS_BIT];
  assign overflowPinEnable       = regFile_reg[adc_ctrl_pkg::IDX_OVR_PIN][0];
  assign outputChannelSelect     = regFile_reg[adc_ctrl_pkg::IDX_OUT_ASSIGN][0];
  assign gainCorrEnable          = regFile_reg[adc_ctrl_pkg::IDX_IQ_EN_FRZ][adc_ctrl_pkg::IQ_EN_GAIN_BIT];
  assign phaseCorrEnable         = regFile_reg[adc_ctrl_pkg::IDX_IQ_EN_FRZ][adc_ctrl_pkg::IQ_EN_PHASE_BIT];
  assign dcCorrEnable            = regFile_reg[adc_ctrl_pkg::IDX_IQ_EN_FRZ][adc_ctrl_pkg::IQ_EN_DC_BIT];
  // A freeze keeps correction applied; the datapath only stops its estimator
  assign gainFreeze              = regFile_reg[adc_ctrl_pkg::IDX_IQ_EN_FRZ][adc_ctrl_pkg::IQ_FRZ_GAIN_BIT];
  assign phaseFreeze             = regFile_reg[adc_ctrl_pkg::IDX_IQ_EN_FRZ][adc_ctrl_pkg::IQ_FRZ_PHASE_BIT];
  assign dcFreeze                = regFile_reg[adc_ctrl_pkg::IDX_IQ_EN_FRZ][adc_ctrl_pkg::IQ_FRZ_DC_BIT];
  assign gainForceStatic         = regFile_reg[adc_ctrl_pkg::IDX_IQ_FORCE][adc_ctrl_pkg::IQ_FORCE_GAIN_BIT];
  assign phaseForceStatic        = regFile_reg[adc_ctrl_pkg::IDX_IQ_FORCE][adc_ctrl_pkg::IQ_FORCE_PHASE_BIT];
  assign dcForceStatic           = regFile_reg[adc_ctrl_pkg::IDX_IQ_FORCE][adc_ctrl_pkg::IQ_FORCE_DC_BIT];
  assign gainLoopExponent        = regFile_reg[adc_ctrl_pkg::IDX_GAIN_BW][4:0];
  assign phaseLoopExponent       = regFile_reg[adc_ctrl_pkg::IDX_PHASE_BW][4:0];
  assign dcLoopExponent          = regFile_reg[adc_ctrl_pkg::IDX_DC_BW][4:0];
  assign initialGain             = {regFile_reg[adc_ctrl_pkg::IDX_GAIN_HI][6:0],
                                    regFile_reg[adc_ctrl_pkg::IDX_GAIN_LO]};
  assign initialPhase            = {regFile_reg[adc_ctrl_pkg::IDX_PHASE_HI][4:0],
                                    regFile_reg[adc_ctrl_pkg::IDX_PHASE_LO]};
  assign initialDcInphase        = {regFile_reg[adc_ctrl_pkg::IDX_DCI_HI][5:0],
                                    regFile_reg[adc_ctrl_pkg::IDX_DCI_LO]};
  assign initialDcQuadrature     = {regFile_reg[adc_ctrl_pkg::IDX_DCQ_HI][5:0],
                                    regFile_reg[adc_ctrl_pkg::IDX_DCQ_LO]};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence oneShotTaken;
    passPulse && nextOnly && !wrSync;
  endsequence

  sequence quietSync;
    !wrSync [*4];
  endsequence

  chk_master_gate: assert property (dividerSyncPulse |-> $past(masterEn))
    else $error("Divider sync pulse without master sync enable");
  chk_divider_gate: assert property (dividerSyncPulse |-> $past(divEn) && $past(syncEdge))
    else $error("Divider sync pulse without divider sync enable");
  chk_continuous_keep: assert property (passPulse && !nextOnly && !wrSync |=> divEn && dividerSyncPulse)
    else $error("Continuous mode lost its enable or pulse");
  chk_one_shot_clear: assert property (oneShotTaken |=> !divEn)
    else $error("One-shot sync did not clear divider enable");
  chk_one_shot_ignore: assert property (oneShotTaken ##1 quietSync |=> !dividerSyncPulse [*3])
    else $error("Pulse passed after one-shot sync");
  chk_oe_pin_ignored: assert property (!oePinEn ##1 1'b1 |-> dataOutputEnable)
    else $error("Output-enable pin acted while disabled");
  chk_oe_pin_follow: assert property (oePinEn |=> dataOutputEnable == !$past(oePinSafe_reg))
    else $error("Outputs do not follow output-enable pin");
  chk_run_oscillator: assert property (runOsc |=> backupLowRateOscillator)
    else $error("Run bit did not start backup oscillator");
  chk_detector_off: assert property (!detectEn && !runOsc ##1 !detectEn && !runOsc |=> !backupLowRateOscillator)
    else $error("Backup oscillator on with detector off");
  chk_slow_encode: assert property (detectEn && !encEdge [*8] ##1
    (detectEn && periodCnt_reg == adc_ctrl_pkg::LOW_RATE_CYCLES) |-> ##[1:2] backupLowRateOscillator)
    else $error("Slow encode clock did not start backup oscillator");
  chk_open_bits_zero: assert property (regRdEn && accessIdx == 5'(adc_ctrl_pkg::IDX_SYNC)
    |=> regRdData[7:3] == 5'h00)
    else $error("Open sync control bits read non-zero");
  chk_unmapped_zero: assert property (regRdEn && accessIdx == 5'(adc_ctrl_pkg::NUM_REGS)
    |=> regRdValid && regRdData == 8'h00)
    else $error("Unmapped read returned data");
endmodule
`default_nettype wire

// *** inc/adc_ctrl_pkg.sv ***
// Register map, field positions, reset values and timing of the converter control bank.
// Assumes a serial control port decoder outside that issues single-cycle byte accesses.
package adc_ctrl_pkg;
  localparam int          ADDR_W   = 13;
  localparam int          NUM_REGS = 17;
  localparam int          IDX_W    = 5;

  localparam logic [12:0] OFS_OVR_PIN    = 13'h002a;
  localparam logic [12:0] OFS_OUT_ASSIGN = 13'h002e;
  localparam logic [12:0] OFS_SYNC       = 13'h0100;
  localparam logic [12:0] OFS_USER_PIN   = 13'h0101;
  localparam logic [12:0] OFS_IQ_EN_FRZ  = 13'h0110;
  localparam logic [12:0] OFS_IQ_FORCE   = 13'h0111;
  localparam logic [12:0] OFS_GAIN_BW    = 13'h0112;
  localparam logic [12:0] OFS_PHASE_BW   = 13'h0113;
  localparam logic [12:0] OFS_DC_BW      = 13'h0114;
  localparam logic [12:0] OFS_GAIN_LO    = 13'h0116;
  localparam logic [12:0] OFS_GAIN_HI    = 13'h0117;
  localparam logic [12:0] OFS_PHASE_LO   = 13'h0118;
  localparam logic [12:0] OFS_PHASE_HI   = 13'h0119;
  localparam logic [12:0] OFS_DCI_LO     = 13'h011a;
  localparam logic [12:0] OFS_DCI_HI     = 13'h011b;
  localparam logic [12:0] OFS_DCQ_LO     = 13'h011c;
  localparam logic [12:0] OFS_DCQ_HI     = 13'h011d;

  localparam int IDX_OVR_PIN = 0;
  localparam int IDX_OUT_ASSIGN = 1;
  localparam int IDX_SYNC = 2;
  localparam int IDX_USER_PIN = 3;
  localparam int IDX_IQ_EN_FRZ = 4;
  localparam int IDX_IQ_FORCE = 5;
  localparam int IDX_GAIN_BW = 6;
  localparam int IDX_PHASE_BW = 7;
  localparam int IDX_DC_BW = 8;
  localparam int IDX_GAIN_LO = 9;
  localparam int IDX_GAIN_HI = 10;
  localparam int IDX_PHASE_LO = 11;
  localparam int IDX_PHASE_HI = 12;
  localparam int IDX_DCI_LO = 13;
  localparam int IDX_DCI_HI = 14;
  localparam int IDX_DCQ_LO = 15;
  localparam int IDX_DCQ_HI = 16;

  localparam logic [12:0] REG_OFS [NUM_REGS] = '{OFS_OVR_PIN, OFS_OUT_ASSIGN, OFS_SYNC, OFS_USER_PIN,
    OFS_IQ_EN_FRZ, OFS_IQ_FORCE, OFS_GAIN_BW, OFS_PHASE_BW, OFS_DC_BW, OFS_GAIN_LO, OFS_GAIN_HI,
    OFS_PHASE_LO, OFS_PHASE_HI, OFS_DCI_LO, OFS_DCI_HI, OFS_DCQ_LO, OFS_DCQ_HI};
  // Writable bits; open bits stay zero
  localparam logic [7:0]  REG_MASK [NUM_REGS] = '{8'h01, 8'h01, 8'h07, 8'h8d, 8'h3f, 8'h07, 8'h1f,
    8'h1f, 8'h1f, 8'hff, 8'h7f, 8'hff, 8'h1f, 8'hff, 8'h3f, 8'hff, 8'h3f};
  localparam logic [7:0]  REG_RST [NUM_REGS] = '{8'h01, 8'h00, 8'h01, 8'h88, 8'h00, 8'h00, 8'h02,
    8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam int SYNC_MASTER_BIT = 0;
  localparam int SYNC_DIV_EN_BIT = 1;
  localparam int SYNC_NEXT_ONLY_BIT = 2;
  localparam int USR_SDIO_PD_DIS_BIT = 0;
  localparam int USR_RUN_OSC_BIT = 2;
  localparam int USR_DETECT_BIT = 3;
  localparam int USR_OE_PIN_EN_BIT = 7;
  localparam int IQ_EN_GAIN_BIT = 0;
  localparam int IQ_EN_PHASE_BIT = 1;
  localparam int IQ_EN_DC_BIT = 2;
  localparam int IQ_FRZ_GAIN_BIT = 3;
  localparam int IQ_FRZ_PHASE_BIT = 4;
  localparam int IQ_FRZ_DC_BIT = 5;
  localparam int IQ_FORCE_GAIN_BIT = 0;
  localparam int IQ_FORCE_PHASE_BIT = 1;
  localparam int IQ_FORCE_DC_BIT = 2;

  localparam int SYS_CLK_MHZ = 100;
  localparam int LOW_RATE_MSPS = 5;
  localparam int CNT_W = 6;
  localparam logic [5:0] LOW_RATE_CYCLES = 6'(SYS_CLK_MHZ / LOW_RATE_MSPS);
endpackage

// *** tb/tb_adc_sync_clock_qec_control_regs.sv ***
// Self-checking bench for the converter control register bank.
// Assumes the byte port protocol of the bank: one-cycle strobes, read data valid one cycle later.
`timescale 1ns/100ps
`default_nettype none
module tb_adc_sync_clock_qec_control_regs;
  logic        clk_sys;
  logic        rst_b;
  logic [12:0] regAddr;
  logic [7:0]  regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [7:0]  regRdData;
  logic        regRdValid;
  logic        syncPin;
  logic        encodeClkPin;
  logic        outputEnablePin_b;
  logic        dividerSyncPulse;
  logic        dataOutputEnable;
  logic        backupLowRateOscillator;
  logic        sdioPullDownEnable;
  logic        overflowPinEnable;
  logic        outputChannelSelect;
  logic        gainCorrEnable, phaseCorrEnable, dcCorrEnable;
  logic        gainFreeze, phaseFreeze, dcFreeze;
  logic        gainForceStatic, phaseForceStatic, dcForceStatic;
  logic [4:0]  gainLoopExponent, phaseLoopExponent, dcLoopExponent;
  logic [14:0] initialGain;
  logic [12:0] initialPhase;
  logic [13:0] initialDcInphase, initialDcQuadrature;
  logic        encodeRun;
  int          failures;
  int          tests_run;
  int          pulseCount;

  adc_sync_clock_qec_control_regs adc_sync_clock_qec_control_regs_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .syncPin(syncPin), .encodeClkPin(encodeClkPin), .outputEnablePin_b(outputEnablePin_b),
    .dividerSyncPulse(dividerSyncPulse), .dataOutputEnable(dataOutputEnable),
    .backupLowRateOscillator(backupLowRateOscillator), .sdioPullDownEnable(sdioPullDownEnable),
    .overflowPinEnable(overflowPinEnable), .outputChannelSelect(outputChannelSelect),
    .gainCorrEnable(gainCorrEnable), .phaseCorrEnable(phaseCorrEnable), .dcCorrEnable(dcCorrEnable),
    .gainFreeze(gainFreeze), .phaseFreeze(phaseFreeze), .dcFreeze(dcFreeze),
    .gainForceStatic(gainForceStatic), .phaseForceStatic(phaseForceStatic),
    .dcForceStatic(dcForceStatic), .gainLoopExponent(gainLoopExponent),
    .phaseLoopExponent(phaseLoopExponent), .dcLoopExponent(dcLoopExponent),
    .initialGain(initialGain), .initialPhase(initialPhase),
    .initialDcInphase(initialDcInphase), .initialDcQuadrature(initialDcQuadrature)
  );

  always #5 clk_sys = ~clk_sys;
  // Encode clock of 80 ns period is well above the low-rate threshold; it stops when encodeRun drops
  always #40 if (encodeRun) encodeClkPin = ~encodeClkPin;
  always @(posedge clk_sys) if (dividerSyncPulse === 1'b1) pulseCount++;

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk_sys);
    #1 regWrEn = 1'b0;
  endtask

  // The read answer is registered, so it is looked at just after the edge following the strobe
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    #1 regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk_sys);
    #1 regRdEn = 1'b0;
    check({15'h0000, regRdValid}, 16'h0001);
    check({8'h00, regRdData}, {8'h00, exp});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Pin high and low long enough for the two-stage synchroniser to see a clean edge
  task automatic sync_edges(input int n, input int expPulses);
    pulseCount = 0;
    repeat (n) begin
      syncPin = 1'b1;
      cycles(4);
      syncPin = 1'b0;
      cycles(6);
    end
    check(pulseCount[15:0], expPulses[15:0]);
  endtask

  initial begin
    #100000;
    failures++;
    report_and_stop();
  end

  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    regAddr = 13'h0000;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    syncPin = 1'b0;
    encodeClkPin = 1'b0;
    outputEnablePin_b = 1'b0;
    encodeRun = 1'b1;
    failures = 0;
    tests_run = 0;
    pulseCount = 0;
    cycles(2);
    rst_b = 1'b1;
    check({14'h0000, sdioPullDownEnable, overflowPinEnable}, 16'h0003);
    for (int i = 0; i < adc_ctrl_pkg::NUM_REGS; i++) rd(adc_ctrl_pkg::REG_OFS[i], adc_ctrl_pkg::REG_RST[i]);
    // Open bits must stay zero after an all-ones write
    for (int i = 0; i < adc_ctrl_pkg::NUM_REGS; i++) begin
      wr(adc_ctrl_pkg::REG_OFS[i], 8'hff);
      rd(adc_ctrl_pkg::REG_OFS[i], adc_ctrl_pkg::REG_MASK[i]);
    end
    wr(13'h0115, 8'hff);
    rd(13'h0115, 8'h00);
    rd(13'h1fff, 8'h00);
    wr(adc_ctrl_pkg::OFS_IQ_EN_FRZ, 8'h15);
    check({10'h000, dcFreeze, phaseFreeze, gainFreeze, dcCorrEnable, phaseCorrEnable, gainCorrEnable}, 16'h0015);
    wr(adc_ctrl_pkg::OFS_IQ_EN_FRZ, 8'h2a);
    check({10'h000, dcFreeze, phaseFreeze, gainFreeze, dcCorrEnable, phaseCorrEnable, gainCorrEnable}, 16'h002a);
    wr(adc_ctrl_pkg::OFS_IQ_FORCE, 8'h05);
    check({13'h0000, dcForceStatic, phaseForceStatic, gainForceStatic}, 16'h0005);
    wr(adc_ctrl_pkg::OFS_IQ_FORCE, 8'h02);
    check({13'h0000, dcForceStatic, phaseForceStatic, gainForceStatic}, 16'h0002);
    wr(adc_ctrl_pkg::OFS_GAIN_BW, 8'he1);
    check({11'h000, gainLoopExponent}, 16'h0001);
    wr(adc_ctrl_pkg::OFS_PHASE_BW, 8'h0a);
    check({11'h000, phaseLoopExponent}, 16'h000a);
    wr(adc_ctrl_pkg::OFS_DC_BW, 8'hf5);
    check({11'h000, dcLoopExponent}, 16'h0015);
    wr(adc_ctrl_pkg::OFS_GAIN_LO, 8'ha5);
    wr(adc_ctrl_pkg::OFS_GAIN_HI, 8'hd2);
    check({1'b0, initialGain}, 16'h52a5);
    wr(adc_ctrl_pkg::OFS_PHASE_LO, 8'h3c);
    wr(adc_ctrl_pkg::OFS_PHASE_HI, 8'hf3);
    check({3'b000, initialPhase}, 16'h133c);
    wr(adc_ctrl_pkg::OFS_DCI_LO, 8'h5a);
    wr(adc_ctrl_pkg::OFS_DCI_HI, 8'hc9);
    check({2'b00, initialDcInphase}, 16'h095a);
    wr(adc_ctrl_pkg::OFS_DCQ_LO, 8'h81);
    wr(adc_ctrl_pkg::OFS_DCQ_HI, 8'h7e);
    check({2'b00, initialDcQuadrature}, 16'h3e81);
    wr(adc_ctrl_pkg::OFS_OVR_PIN, 8'hfe);
    wr(adc_ctrl_pkg::OFS_OUT_ASSIGN, 8'h01);
    check({14'h0000, overflowPinEnable, outputChannelSelect}, 16'h0001);
    // Sync gating: each enable alone must block the divider pulse
    wr(adc_ctrl_pkg::OFS_SYNC, 8'h01);
    sync_edges(1, 0);
    wr(adc_ctrl_pkg::OFS_SYNC, 8'h02);
    sync_edges(1, 0);
    wr(adc_ctrl_pkg::OFS_SYNC, 8'h03);
    sync_edges(3, 3);
    rd(adc_ctrl_pkg::OFS_SYNC, 8'h03);
    wr(adc_ctrl_pkg::OFS_SYNC, 8'h07);
    sync_edges(3, 1);
    rd(adc_ctrl_pkg::OFS_SYNC, 8'h05);
    wr(adc_ctrl_pkg::OFS_SYNC, 8'h07);
    sync_edges(1, 1);
    // Pin control of the outputs, then the pin ignored
    wr(adc_ctrl_pkg::OFS_USER_PIN, 8'h80);
    outputEnablePin_b = 1'b1;
    cycles(5);
    check({15'h0000, dataOutputEnable}, 16'h0000);
    outputEnablePin_b = 1'b0;
    cycles(5);
    check({15'h0000, dataOutputEnable}, 16'h0001);
    outputEnablePin_b = 1'b1;
    wr(adc_ctrl_pkg::OFS_USER_PIN, 8'h01);
    cycles(5);
    check({14'h0000, dataOutputEnable, sdioPullDownEnable}, 16'h0002);
    // Rate detect: a fast encode clock keeps the oscillator off, a stopped one turns it on
    wr(adc_ctrl_pkg::OFS_USER_PIN, 8'h08);
    cycles(40);
    check({15'h0000, backupLowRateOscillator}, 16'h0000);
    encodeRun = 1'b0;
    cycles(30);
    check({15'h0000, backupLowRateOscillator}, 16'h0001);
    wr(adc_ctrl_pkg::OFS_USER_PIN, 8'h00);
    cycles(2);
    check({15'h0000, backupLowRateOscillator}, 16'h0000);
    wr(adc_ctrl_pkg::OFS_USER_PIN, 8'h04);
    cycles(2);
    check({15'h0000, backupLowRateOscillator}, 16'h0001);
    encodeRun = 1'b1;
    cycles(40);
    check({15'h0000, backupLowRateOscillator}, 16'h0001);
    report_and_stop();
  end
endmodule
`default_nettype wire
